// File: hdl/spw_wake_enable.sv
/*
  Soft power wake enable block: enable registers, wake status, power-on
  request output and interrupt logic behind an AHB-Lite slave.
  Assumes wake pins synchronous to hclk, hresetn is the battery power-on
  reset, and standby_reset is a one-cycle pulse of the standby supply reset.
*/
// Functional notes
// - Set enable lets source wake; clear blocks
// - First register bits 0,1 gate ring indicators
// - First register bits 2,3 gate keyboard, mouse
// - First register bits 4,5 gate group interrupts
// - Bit 6 gates infrared input; bit 7 reserved
// - Second register bits 0,1 gate serial receive
// - Second register bit 3 gates dedicated ring
// - Bit 4: standby reset floats output inactive
// - Neither bit: output keeps state over reset
// - Bit 6 with bit 4 clear: standby reset drives output low
// - Battery reset: 0x00 and 0x80 values
// - Bit 6 powers machine up only at standby reset
// - First register falling edges latched as type-one events
// - Status read clears latched; group bits live
`timescale 1ns/1ps
module spw_wake_enable (
  // Clock and battery reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Wake pins
  input wire logic ring_a_n,
  input wire logic ring_b_n,
  input wire logic keyboard_data,
  input wire logic mouse_data,
  input wire logic infrared_rx_b,
  input wire logic serial_rx_a,
  input wire logic serial_rx_b,
  input wire logic ring_input_n,
  input wire logic group_irq_a,
  input wire logic group_irq_b,
  // Standby supply reset pulse
  input wire logic standby_reset,
  // Open-drain power-on request and interrupt
  output logic power_on_request_n,
  output logic power_on_oe,
  output logic irq
);
  logic [7:0] wake_enable_one;
  logic [7:0] wake_enable_two;
  logic [7:0] wake_status;
  logic [spw_pkg::IRQ_W-1:0] irq_status;
  logic [spw_pkg::IRQ_W-1:0] irq_enable;
  logic power_active;
  logic wr_pend;
  logic [spw_pkg::ADDR_W-1:0] wr_addr;
  logic [7:0] next_enable_one;
  logic [7:0] next_enable_two;
  logic [7:0] next_status;
  logic [spw_pkg::IRQ_W-1:0] next_irq_status;
  logic [spw_pkg::IRQ_W-1:0] next_irq_enable;
  logic next_power_active;
  logic next_wr_pend;
  logic [spw_pkg::ADDR_W-1:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic [spw_pkg::NUM_SRC-1:0] pins;
  logic [spw_pkg::NUM_SRC-1:0] fall;
  logic [spw_pkg::NUM_SRC-1:0] src_enable;
  logic [7:0] latch_set;
  logic group_wake;
  logic wake;
  logic acc;
  logic acc_rd;
  logic [spw_pkg::ADDR_W-1:0] acc_addr;
  logic wr_data;
  logic [7:0] wbyte;
  logic release_req;
  logic [spw_pkg::IRQ_W-1:0] irq_set;
  logic [spw_pkg::IRQ_W-1:0] irq_clr;
  logic seen_clk;

  // Pin bundle for the edge detectors
  assign pins[spw_pkg::SRC_RING_A] = ring_a_n;
  assign pins[spw_pkg::SRC_RING_B] = ring_b_n;
  assign pins[spw_pkg::SRC_KEYBOARD] = keyboard_data;
  assign pins[spw_pkg::SRC_MOUSE] = mouse_data;
  assign pins[spw_pkg::SRC_INFRARED] = infrared_rx_b;
  assign pins[spw_pkg::SRC_RX_A] = serial_rx_a;
  assign pins[spw_pkg::SRC_RX_B] = serial_rx_b;
  assign pins[spw_pkg::SRC_RING_PIN] = ring_input_n;

  spw_fall_detect #(
    .WIDTH(spw_pkg::NUM_SRC)
  ) u_fall (
    .hclk(hclk),
    .hresetn(hresetn),
    .pins(pins),
    .fall(fall)
  );

  // Enable bit of each edge source
  always_comb begin
    src_enable[spw_pkg::SRC_RING_A] = wake_enable_one[spw_pkg::EN1_RING_A];
    src_enable[spw_pkg::SRC_RING_B] = wake_enable_one[spw_pkg::EN1_RING_B];
    src_enable[spw_pkg::SRC_KEYBOARD] = wake_enable_one[spw_pkg::EN1_KEYBOARD];
    src_enable[spw_pkg::SRC_MOUSE] = wake_enable_one[spw_pkg::EN1_MOUSE];
    src_enable[spw_pkg::SRC_INFRARED] = wake_enable_one[spw_pkg::EN1_INFRARED];
    src_enable[spw_pkg::SRC_RX_A] = wake_enable_two[spw_pkg::EN2_RX_A];
    src_enable[spw_pkg::SRC_RX_B] = wake_enable_two[spw_pkg::EN2_RX_B];
    src_enable[spw_pkg::SRC_RING_PIN] = wake_enable_two[spw_pkg::EN2_RING];
  end

  // Wake decision: enabled edges or enabled group levels
  assign group_wake = (group_irq_a & wake_enable_one[spw_pkg::EN1_GROUP_A])
    | (group_irq_b & wake_enable_one[spw_pkg::EN1_GROUP_B]);
  assign wake = (|(fall & src_enable)) | group_wake;

  // Type-one events latched only when enabled
  always_comb begin
    latch_set = spw_pkg::BYTE_ZERO;
    latch_set[spw_pkg::EN1_RING_A] = fall[spw_pkg::SRC_RING_A] & src_enable[spw_pkg::SRC_RING_A];
    latch_set[spw_pkg::EN1_RING_B] = fall[spw_pkg::SRC_RING_B] & src_enable[spw_pkg::SRC_RING_B];
    latch_set[spw_pkg::EN1_KEYBOARD] = fall[spw_pkg::SRC_KEYBOARD]
      & src_enable[spw_pkg::SRC_KEYBOARD];
    latch_set[spw_pkg::EN1_MOUSE] = fall[spw_pkg::SRC_MOUSE] & src_enable[spw_pkg::SRC_MOUSE];
    latch_set[spw_pkg::EN1_INFRARED] = fall[spw_pkg::SRC_INFRARED]
      & src_enable[spw_pkg::SRC_INFRARED];
  end

  // Bus transfer qualification
  assign acc = hsel & htrans[spw_pkg::HTRANS_ACTIVE_BIT] & hready;
  assign acc_rd = acc & ~hwrite;
  assign acc_addr = haddr[spw_pkg::ADDR_W-1:0];
  assign wr_data = wr_pend;
  assign wbyte = hwdata[7:0];
  assign release_req = wr_data && (wr_addr == spw_pkg::ADDR_POWER_CTRL)
    && wbyte[spw_pkg::CTRL_RELEASE];

  // Interrupt events and software clear
  always_comb begin
    irq_set = '0;
    irq_set[spw_pkg::IRQ_WAKE] = wake;
    irq_set[spw_pkg::IRQ_STANDBY] = standby_reset;
    irq_clr = '0;
    if (wr_data && (wr_addr == spw_pkg::ADDR_IRQ_CLEAR)) begin
      irq_clr = wbyte[spw_pkg::IRQ_W-1:0];
    end
  end

  // Next register values
  always_comb begin
    next_wr_pend = acc & hwrite;
    next_wr_addr = acc ? acc_addr : wr_addr;
    next_enable_one = wake_enable_one;
    next_enable_two = wake_enable_two;
    next_irq_enable = irq_enable;
    if (wr_data && (wr_addr == spw_pkg::ADDR_EN_ONE)) begin
      next_enable_one = wbyte & spw_pkg::WR_MASK_EN_ONE;
    end
    if (wr_data && (wr_addr == spw_pkg::ADDR_EN_TWO)) begin
      next_enable_two = wbyte & spw_pkg::WR_MASK_EN_TWO;
    end
    if (wr_data && (wr_addr == spw_pkg::ADDR_IRQ_ENABLE)) begin
      next_irq_enable = wbyte[spw_pkg::IRQ_W-1:0];
    end
    // Set wins over clear
    next_irq_status = (irq_status & ~irq_clr) | irq_set;
    next_status = wake_status;
    if (acc_rd && (acc_addr == spw_pkg::ADDR_WAKE_STATUS)) begin
      next_status = wake_status & ~spw_pkg::STATUS_LATCH_MASK;
    end
    next_status = next_status | latch_set;
  end

  // Power-on request state
  always_comb begin
    next_power_active = power_active;
    if (standby_reset) begin
      if (wake_enable_two[spw_pkg::EN2_POR_OFF]) begin
        next_power_active = 1'b0;
      end else if (wake_enable_two[spw_pkg::EN2_POR_ON]) begin
        next_power_active = 1'b1;
      end else begin
        next_power_active = power_active;
      end
    end else if (wake) begin
      next_power_active = 1'b1;
    end else if (release_req) begin
      next_power_active = 1'b0;
    end
  end

  // Read data; enable registers taken from updated values to see a write just ahead
  always_comb begin
    next_hrdata = hrdata;
    if (acc_rd) begin
      next_hrdata = '0;
      case (acc_addr)
        spw_pkg::ADDR_EN_ONE: next_hrdata[7:0] = next_enable_one;
        spw_pkg::ADDR_EN_TWO: next_hrdata[7:0] = next_enable_two;
        spw_pkg::ADDR_WAKE_STATUS: begin
          next_hrdata[7:0] = wake_status & spw_pkg::STATUS_LATCH_MASK;
          next_hrdata[spw_pkg::EN1_GROUP_A] = group_irq_a;
          next_hrdata[spw_pkg::EN1_GROUP_B] = group_irq_b;
        end
        spw_pkg::ADDR_IRQ_STATUS: next_hrdata[spw_pkg::IRQ_W-1:0] = irq_status;
        spw_pkg::ADDR_IRQ_ENABLE: next_hrdata[spw_pkg::IRQ_W-1:0] = next_irq_enable;
        default: next_hrdata = '0;
      endcase
    end
  end

  // Registers; battery reset sets the documented defaults
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_enable_one <= spw_pkg::RST_EN_ONE;
      wake_enable_two <= spw_pkg::RST_EN_TWO;
      wake_status <= spw_pkg::BYTE_ZERO;
      irq_status <= '0;
      irq_enable <= '0;
      power_active <= 1'b0;
      power_on_request_n <= 1'b1;
      power_on_oe <= 1'b0;
      irq <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= '0;
      hreadyout <= 1'b0;
      hresp <= spw_pkg::HRESP_OKAY;
      seen_clk <= 1'b0;
    end else begin
      wake_enable_one <= next_enable_one;
      wake_enable_two <= next_enable_two;
      wake_status <= next_status;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      power_active <= next_power_active;
      power_on_request_n <= ~next_power_active;
      power_on_oe <= next_power_active;
      irq <= |(next_irq_status & next_irq_enable);
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= spw_pkg::HRESP_OKAY;
      seen_clk <= 1'b1;
    end
  end

  // Checks on the power-on output, registers and status
  property p_wake_on;
    @(posedge hclk) disable iff (!hresetn)
      (wake && !standby_reset) |=> (power_on_oe && !power_on_request_n);
  endproperty
  a_wake_on: assert property (p_wake_on)
    else $error("enabled wake did not assert power-on");

  property p_disabled_ignored;
    @(posedge hclk) disable iff (!hresetn)
      (!power_active && !standby_reset && !(|(fall & src_enable)) && !group_wake)
      |=> (!power_on_oe && power_on_request_n);
  endproperty
  a_disabled_ignored: assert property (p_disabled_ignored)
    else $error("power-on asserted without enabled wake");

  property p_por_off;
    @(posedge hclk) disable iff (!hresetn)
      (standby_reset && wake_enable_two[spw_pkg::EN2_POR_OFF])
      |=> (!power_on_oe && power_on_request_n);
  endproperty
  a_por_off: assert property (p_por_off)
    else $error("standby reset did not float power-on");

  property p_por_on;
    @(posedge hclk) disable iff (!hresetn)
      (standby_reset && !wake_enable_two[spw_pkg::EN2_POR_OFF]
      && wake_enable_two[spw_pkg::EN2_POR_ON]) |=> (power_on_oe && !power_on_request_n);
  endproperty
  a_por_on: assert property (p_por_on)
    else $error("standby reset did not drive power-on");

  property p_por_hold;
    @(posedge hclk) disable iff (!hresetn)
      (standby_reset && !wake_enable_two[spw_pkg::EN2_POR_OFF]
      && !wake_enable_two[spw_pkg::EN2_POR_ON]) |=> (power_on_oe == $past(power_on_oe));
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("power-on changed over standby reset");

  property p_reset_values;
    @(posedge hclk) disable iff (!hresetn)
      !seen_clk |-> (wake_enable_one == spw_pkg::RST_EN_ONE
      && wake_enable_two == spw_pkg::RST_EN_TWO);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("enable registers wrong after reset");

  property p_status_clear;
    @(posedge hclk) disable iff (!hresetn)
      (acc_rd && acc_addr == spw_pkg::ADDR_WAKE_STATUS && latch_set == spw_pkg::BYTE_ZERO)
      |=> ((wake_status & spw_pkg::STATUS_LATCH_MASK) == spw_pkg::BYTE_ZERO);
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status read did not clear latched bits");

  property p_keyboard_latch;
    @(posedge hclk) disable iff (!hresetn)
      (fall[spw_pkg::SRC_KEYBOARD] && wake_enable_one[spw_pkg::EN1_KEYBOARD])
      |=> wake_status[spw_pkg::EN1_KEYBOARD] ##1 wake_status[spw_pkg::EN1_KEYBOARD]
      || $past(acc_rd);
  endproperty
  a_keyboard_latch: assert property (p_keyboard_latch)
    else $error("keyboard edge not latched");

  property p_ring_pin;
    @(posedge hclk) disable iff (!hresetn)
      (fall[spw_pkg::SRC_RING_PIN] && wake_enable_two[spw_pkg::EN2_RING] && !standby_reset)
      |=> power_active;
  endproperty
  a_ring_pin: assert property (p_ring_pin)
    else $error("ring pin wake ignored");

  property p_reserved_zero;
    @(posedge hclk) disable iff (!hresetn)
      ((wake_enable_one & ~spw_pkg::WR_MASK_EN_ONE) == spw_pkg::BYTE_ZERO)
      && ((wake_enable_two & ~spw_pkg::WR_MASK_EN_TWO) == spw_pkg::BYTE_ZERO);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved enable bit set");
endmodule

// File: shared/spw_pkg.sv
/*
  Constants for the soft power wake enable block: register indices and byte
  addresses, reset values, writable masks, field positions and source order.
  Assumes an AHB-Lite slave with 32-bit data, one register per aligned word.
*/
package spw_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_EN_ONE = 8'hb0;
  localparam logic [7:0] IDX_EN_TWO = 8'hb1;
  localparam logic [7:0] IDX_WAKE_STATUS = 8'hb2;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hc0;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'hc1;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hc2;
  localparam logic [7:0] IDX_POWER_CTRL = 8'hc3;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_EN_ONE = {2'b00, IDX_EN_ONE, 2'b00};
  localparam logic [11:0] ADDR_EN_TWO = {2'b00, IDX_EN_TWO, 2'b00};
  localparam logic [11:0] ADDR_WAKE_STATUS = {2'b00, IDX_WAKE_STATUS, 2'b00};
  localparam logic [11:0] ADDR_IRQ_STATUS = {2'b00, IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] ADDR_IRQ_CLEAR = {2'b00, IDX_IRQ_CLEAR, 2'b00};
  localparam logic [11:0] ADDR_IRQ_ENABLE = {2'b00, IDX_IRQ_ENABLE, 2'b00};
  localparam logic [11:0] ADDR_POWER_CTRL = {2'b00, IDX_POWER_CTRL, 2'b00};
  // Reset values and writable bits
  localparam logic [7:0] RST_EN_ONE = 8'h00;
  localparam logic [7:0] RST_EN_TWO = 8'h80;
  localparam logic [7:0] WR_MASK_EN_ONE = 8'h7f;
  localparam logic [7:0] WR_MASK_EN_TWO = 8'hdb;
  localparam logic [7:0] STATUS_LATCH_MASK = 8'h4f;
  // First enable register fields (status register shares the layout)
  localparam int EN1_RING_A = 0;
  localparam int EN1_RING_B = 1;
  localparam int EN1_KEYBOARD = 2;
  localparam int EN1_MOUSE = 3;
  localparam int EN1_GROUP_A = 4;
  localparam int EN1_GROUP_B = 5;
  localparam int EN1_INFRARED = 6;
  // Second enable register fields
  localparam int EN2_RX_A = 0;
  localparam int EN2_RX_B = 1;
  localparam int EN2_RING = 3;
  localparam int EN2_POR_OFF = 4;
  localparam int EN2_POR_ON = 6;
  // Order of edge-detected wake sources
  localparam int NUM_SRC = 8;
  localparam int SRC_RING_A = 0;
  localparam int SRC_RING_B = 1;
  localparam int SRC_KEYBOARD = 2;
  localparam int SRC_MOUSE = 3;
  localparam int SRC_INFRARED = 4;
  localparam int SRC_RX_A = 5;
  localparam int SRC_RX_B = 6;
  localparam int SRC_RING_PIN = 7;
  // Interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_STANDBY = 1;
  // Power control register release bit
  localparam int CTRL_RELEASE = 0;
  // Bus constants
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// File: hdl/spw_fall_detect.sv
/*
  Falling edge detector for a group of wake pins, one stage per pin.
  Assumes the pins are already synchronous to hclk and idle high.
*/
`timescale 1ns/1ps
module spw_fall_detect #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pins and edge pulses
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_prev;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // High-to-low transition seen against last sample
      always_comb begin
        next_prev[i] = pins[i];
        fall[i] = prev[i] & ~pins[i];
      end

      // Previous level, idle high out of reset
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          prev[i] <= 1'b1;
        end else begin
          prev[i] <= next_prev[i];
        end
      end
    end
  endgenerate
endmodule

// File: test/spw_power_supply.sv
/*
  Behavioural model of the system power supply behind the open-drain
  power-on request. Assumes a pull-up on the wire and that the supply
  runs while the wire is held low.
*/
`timescale 1ns/1ps
module spw_power_supply (
  // Open-drain request from the block
  input wire logic power_on_request_n,
  input wire logic power_on_oe,
  // Wire level and supply state
  output logic pin_level,
  output logic powered
);
  // Pull-up wins whenever the block is not sinking the wire
  assign pin_level = (power_on_oe && !power_on_request_n) ? 1'b0 : 1'b1;
  // Supply is switched on by a low wire
  assign powered = ~pin_level;
endmodule

// File: test/spw_wake_enable_test.sv
/*
  Self-checking testbench for the soft power wake enable block.
  Assumes one AHB-Lite slave whose hreadyout is the bus hready, and the
  power supply model on the open-drain power-on request.
*/
`timescale 1ns/1ps
module spw_wake_enable_test;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, standby_reset;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [9:0] pins;
  logic power_on_request_n, power_on_oe, irq, pin_level, powered;
  int fail_count, n_compared;

  // Block under test; pins 0..7 idle high, 8..9 group levels
  spw_wake_enable u_spw_wake_enable (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ring_a_n(pins[0]), .ring_b_n(pins[1]), .keyboard_data(pins[2]),
    .mouse_data(pins[3]), .infrared_rx_b(pins[4]), .serial_rx_a(pins[5]),
    .serial_rx_b(pins[6]), .ring_input_n(pins[7]), .group_irq_a(pins[8]),
    .group_irq_b(pins[9]), .standby_reset(standby_reset),
    .power_on_request_n(power_on_request_n), .power_on_oe(power_on_oe), .irq(irq)
  );

  // Power supply on the far side
  spw_power_supply u_spw_power_supply (
    .power_on_request_n(power_on_request_n), .power_on_oe(power_on_oe),
    .pin_level(pin_level), .powered(powered)
  );

  // Clock at 200 MHz
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // Counts and reports one comparison
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic summarize;
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Waits for hready high at a rising edge; only the watchdog ends a hang
  task automatic wait_ready;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
    end
  endtask

  // One single-word AHB-Lite transfer
  task automatic bus(input logic is_wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h00000, a};
    hwrite <= is_wr;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready;
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h000000, d});
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp, input string m);
    bus(1'b0, a, 32'h00000000);
    check(rd, {24'h000000, exp}, m);
  endtask

  // Power request state seen at the pin and by the supply
  task automatic power_is(input logic on, input string m);
    check({31'h0, power_on_oe}, {31'h0, on}, m);
    check({31'h0, power_on_request_n}, {31'h0, ~on}, m);
    check({31'h0, powered}, {31'h0, on}, m);
  endtask

  // Standby supply reset pulse of one cycle
  task automatic standby_pulse;
    @(posedge hclk);
    standby_reset <= 1'b1;
    @(posedge hclk);
    standby_reset <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask

  // Reset values, writable bits, unmapped place, second battery reset
  task automatic reg_access;
    rdchk(spw_pkg::ADDR_EN_ONE, 8'h00, "enable one reset");
    rdchk(spw_pkg::ADDR_EN_TWO, 8'h80, "enable two reset");
    power_is(1'b0, "power after reset");
    wr(spw_pkg::ADDR_EN_ONE, 8'hff);
    rdchk(spw_pkg::ADDR_EN_ONE, 8'h7f, "enable one reserved bit");
    wr(spw_pkg::ADDR_EN_TWO, 8'h8b);
    rdchk(spw_pkg::ADDR_EN_TWO, 8'h8b, "enable two bits");
    wr(spw_pkg::ADDR_EN_TWO, 8'h24);
    rdchk(spw_pkg::ADDR_EN_TWO, 8'h00, "enable two reserved bits");
    rdchk(12'h010, 8'h00, "unmapped read");
    check({31'h0, hresp}, 32'h0, "response code");
    check({31'h0, hreadyout}, 32'h1, "ready after reset");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    check({31'h0, hreadyout}, 32'h0, "ready in reset");
    power_is(1'b0, "power in reset");
    hresetn <= 1'b1;
    rdchk(spw_pkg::ADDR_EN_ONE, 8'h00, "enable one after reset");
    rdchk(spw_pkg::ADDR_EN_TWO, 8'h80, "enable two after reset");
  endtask

  // One wake source: blocked when disabled, wakes when enabled; status must read sbit
  task wake_src(input int p, input logic [11:0] a, input logic [7:0] en,
                          input logic [7:0] sbit);
    wr(spw_pkg::ADDR_EN_ONE, 8'h00);
    wr(spw_pkg::ADDR_EN_TWO, 8'h80);
    @(posedge hclk);
    pins[p] <= ~pins[p];
    repeat (4) @(posedge hclk);
    pins[p] <= ~pins[p];
    repeat (4) @(posedge hclk);
    power_is(1'b0, "disabled source");
    wr(a, en);
    @(posedge hclk);
    pins[p] <= ~pins[p];
    repeat (4) @(posedge hclk);
    power_is(1'b1, "enabled source");
    rdchk(spw_pkg::ADDR_WAKE_STATUS, sbit, "status set");
    @(posedge hclk);
    pins[p] <= ~pins[p];
    repeat (2) @(posedge hclk);
    rdchk(spw_pkg::ADDR_WAKE_STATUS, 8'h00, "status cleared");
    wr(spw_pkg::ADDR_POWER_CTRL, 8'h01);
    repeat (2) @(posedge hclk);
    power_is(1'b0, "release write");
    check({31'h0, irq}, 32'h0, "masked irq");
  endtask

  // Power request across standby supply resets
  task automatic standby_cases;
    wr(spw_pkg::ADDR_EN_TWO, 8'h80);
    standby_pulse;
    power_is(1'b0, "off kept over standby reset");
    wr(spw_pkg::ADDR_EN_ONE, 8'h04);
    @(posedge hclk);
    pins[2] <= 1'b0;
    repeat (4) @(posedge hclk);
    pins[2] <= 1'b1;
    standby_pulse;
    power_is(1'b1, "on kept over standby reset");
    wr(spw_pkg::ADDR_EN_TWO, 8'h90);
    standby_pulse;
    power_is(1'b0, "standby reset powers off");
    wr(spw_pkg::ADDR_EN_TWO, 8'hc0);
    standby_pulse;
    power_is(1'b1, "standby reset powers on");
    wr(spw_pkg::ADDR_EN_TWO, 8'h80);
    wr(spw_pkg::ADDR_POWER_CTRL, 8'h01);
    rdchk(spw_pkg::ADDR_WAKE_STATUS, 8'h04, "keyboard latched");
  endtask

  // Interrupt raised, masked and cleared
  task automatic irq_cases;
    wr(spw_pkg::ADDR_IRQ_CLEAR, 8'h03);
    wr(spw_pkg::ADDR_IRQ_ENABLE, 8'h01);
    @(posedge hclk);
    pins[2] <= 1'b0;
    repeat (4) @(posedge hclk);
    pins[2] <= 1'b1;
    check({31'h0, irq}, 32'h1, "wake irq");
    rdchk(spw_pkg::ADDR_IRQ_STATUS, 8'h01, "wake irq status");
    wr(spw_pkg::ADDR_POWER_CTRL, 8'h01);
    wr(spw_pkg::ADDR_IRQ_CLEAR, 8'h01);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    standby_pulse;
    check({31'h0, irq}, 32'h0, "standby irq masked");
    rdchk(spw_pkg::ADDR_IRQ_STATUS, 8'h02, "standby irq status");
    wr(spw_pkg::ADDR_IRQ_ENABLE, 8'h02);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h1, "standby irq");
    rdchk(spw_pkg::ADDR_IRQ_CLEAR, 8'h00, "clear reads zero");
    wr(spw_pkg::ADDR_IRQ_CLEAR, 8'h02);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0, "standby irq cleared");
  endtask

  // Main sequence
  initial begin
    fail_count = 0;
    n_compared = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    pins = 10'h0ff;
    standby_reset = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    reg_access;
    wake_src(0, spw_pkg::ADDR_EN_ONE, 8'h01, 8'h01);
    wake_src(1, spw_pkg::ADDR_EN_ONE, 8'h02, 8'h02);
    wake_src(2, spw_pkg::ADDR_EN_ONE, 8'h04, 8'h04);
    wake_src(3, spw_pkg::ADDR_EN_ONE, 8'h08, 8'h08);
    wake_src(8, spw_pkg::ADDR_EN_ONE, 8'h10, 8'h10);
    wake_src(9, spw_pkg::ADDR_EN_ONE, 8'h20, 8'h20);
    wake_src(4, spw_pkg::ADDR_EN_ONE, 8'h40, 8'h40);
    wake_src(5, spw_pkg::ADDR_EN_TWO, 8'h81, 8'h00);
    wake_src(6, spw_pkg::ADDR_EN_TWO, 8'h82, 8'h00);
    wake_src(7, spw_pkg::ADDR_EN_TWO, 8'h88, 8'h00);
    standby_cases;
    irq_cases;
    summarize;
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    summarize;
  end
endmodule
